// file: rtl/carctc_pkg.sv
// package for the current adc result counter and threshold block
package carctc_pkg;
   localparam logic [31:0] ADDR_COUNT_LIMIT = 32'hffff_0548;
   localparam logic [31:0] ADDR_COUNT_VALUE = 32'hffff_054c;
   localparam logic [31:0] ADDR_THRESHOLD = 32'hffff_0550;
   localparam logic [31:0] ADDR_THR_LIMIT = 32'hffff_0554;
   localparam logic [31:0] ADDR_THR_VALUE = 32'hffff_0558;
   localparam logic [31:0] ADDR_CONFIG = 32'hffff_0600;
   localparam logic [31:0] ADDR_CHAN_CTRL = 32'hffff_0604;
   localparam logic [31:0] ADDR_MODE = 32'hffff_0608;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'hffff_060c;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'hffff_0610;
   localparam logic [15:0] RST_COUNT_LIMIT = 16'h0001;
   localparam logic [15:0] RST_COUNT_VALUE = 16'h0000;
   localparam logic [15:0] RST_THRESHOLD = 16'h0000;
   localparam logic [7:0] RST_THR_LIMIT = 8'h01;
   localparam logic [7:0] RST_THR_VALUE = 8'h00;
   localparam int CFG_COUNT_EN = 0;
   localparam int CFG_CMP_EN = 1;
   localparam int CFG_CMP_CLEAR = 2;
   localparam int CFG_TWOS = 3;
   localparam int IRQ_CONV = 0;
   localparam int IRQ_THR = 1;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } carctc_bus_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } carctc_result_t;
endpackage

// file: rtl/carctc_top.sv
// result counter and magnitude threshold logic for the current channel
// Notes on behaviour
// - a 16-bit writable limit sets how many conversions precede an interrupt.
// - the conversion count limit resets to one.
// - counting and its interrupt thinning work only while config bit 0 is set.
// - a 16-bit read-only count holds conversions done since last cleared.
// - when one more conversion would bring the count to the limit it clears to zero and counts on.
// - a write to the channel control or mode register clears the count.
// - a 16-bit writable threshold, reset zero, is compared to result magnitude.
// - unipolar compares bits 15..0, two's complement only bits 14..0.
// - an 8-bit count rises on results at or above threshold, else falls or clears.
// - the threshold status bit sets once the count equals the 8-bit limit.
// - the threshold count limit resets to one, the threshold count to zero.
// - config bits enable the comparator and pick decrement or clear.
`timescale 1ns/1ps
`default_nettype none
module carctc_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire carctc_pkg::carctc_bus_t bus,
   output logic [31:0] rdata,
   input wire carctc_pkg::carctc_result_t result,
   output logic irq
);
   logic [15:0] count_limit;
   logic [15:0] count_value;
   logic [15:0] threshold;
   logic [7:0] thr_limit;
   logic [7:0] thr_value;
   logic [3:0] config_bits;
   logic [15:0] chan_ctrl;
   logic [15:0] mode_bits;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic reconfig;
   logic conv_hit;
   logic thr_hit;
   logic above;
   logic [15:0] magnitude;
   logic [15:0] neg_data;
   logic [7:0] next_thr_value;

   assign reconfig = bus.wr && (bus.addr == carctc_pkg::ADDR_CHAN_CTRL ||
      bus.addr == carctc_pkg::ADDR_MODE);

   // software settings
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_limit <= carctc_pkg::RST_COUNT_LIMIT;
         threshold <= carctc_pkg::RST_THRESHOLD;
         thr_limit <= carctc_pkg::RST_THR_LIMIT;
         config_bits <= 4'h0;
         chan_ctrl <= 16'h0000;
         mode_bits <= 16'h0000;
         irq_mask <= 2'h0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            carctc_pkg::ADDR_COUNT_LIMIT: begin
               count_limit <= bus.wdata[15:0];
            end
            carctc_pkg::ADDR_THRESHOLD: begin
               threshold <= bus.wdata[15:0];
            end
            carctc_pkg::ADDR_THR_LIMIT: begin
               thr_limit <= bus.wdata[7:0];
            end
            carctc_pkg::ADDR_CONFIG: begin
               config_bits <= bus.wdata[3:0];
            end
            carctc_pkg::ADDR_CHAN_CTRL: begin
               chan_ctrl <= bus.wdata[15:0];
            end
            carctc_pkg::ADDR_MODE: begin
               mode_bits <= bus.wdata[15:0];
            end
            carctc_pkg::ADDR_IRQ_MASK: begin
               irq_mask <= bus.wdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // conversion counter; reconfiguration outranks a coincident result
   assign conv_hit = result.valid && config_bits[carctc_pkg::CFG_COUNT_EN]
      && !reconfig && (count_value + 16'h0001 == count_limit);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_value <= carctc_pkg::RST_COUNT_VALUE;
      end else if (reconfig) begin
         count_value <= 16'h0000;
      end else if (result.valid && config_bits[carctc_pkg::CFG_COUNT_EN]) begin
         if (conv_hit) begin
            count_value <= 16'h0000;
         end else begin
            count_value <= count_value + 16'h0001;
         end
      end
   end

   // magnitude of the result, sign dropped in two's complement coding
   assign neg_data = 16'h0000 - result.data;
   always_comb begin
      if (config_bits[carctc_pkg::CFG_TWOS]) begin
         magnitude = result.data[15] ? neg_data : result.data;
         // only 15 threshold bits take part; -32768 saturates high
         above = magnitude[15] ||
            ({1'b0, magnitude[14:0]} >= {1'b0, threshold[14:0]});
      end else begin
         magnitude = result.data;
         above = magnitude >= threshold;
      end
   end

   always_comb begin
      next_thr_value = thr_value;
      if (above) begin
         if (thr_value != 8'hff) begin
            next_thr_value = thr_value + 8'h01;
         end
      end else if (config_bits[carctc_pkg::CFG_CMP_CLEAR]) begin
         next_thr_value = 8'h00;
      end else if (thr_value != 8'h00) begin
         next_thr_value = thr_value - 8'h01;
      end
   end

   assign thr_hit = result.valid && config_bits[carctc_pkg::CFG_CMP_EN]
      && (next_thr_value == thr_limit);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         thr_value <= carctc_pkg::RST_THR_VALUE;
      end else if (!config_bits[carctc_pkg::CFG_CMP_EN]) begin
         thr_value <= 8'h00;
      end else if (result.valid) begin
         thr_value <= next_thr_value;
      end
   end

   // sticky status, set wins over write-one clear
   logic [1:0] status_clear;
   assign status_clear = (bus.wr && bus.addr == carctc_pkg::ADDR_IRQ_STATUS)
      ? bus.wdata[1:0] : 2'h0;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_status <= 2'h0;
      end else begin
         // an event in the clearing cycle must not be lost
         irq_status <= (irq_status & ~status_clear)
            | {thr_hit, conv_hit};
      end
   end
   assign irq = |(irq_status & irq_mask);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         unique case (bus.addr)
            carctc_pkg::ADDR_COUNT_LIMIT: begin
               rdata <= {16'h0000, count_limit};
            end
            carctc_pkg::ADDR_COUNT_VALUE: begin
               rdata <= {16'h0000, count_value};
            end
            carctc_pkg::ADDR_THRESHOLD: begin
               rdata <= {16'h0000, threshold};
            end
            carctc_pkg::ADDR_THR_LIMIT: begin
               rdata <= {24'h00_0000, thr_limit};
            end
            carctc_pkg::ADDR_THR_VALUE: begin
               rdata <= {24'h00_0000, thr_value};
            end
            carctc_pkg::ADDR_CONFIG: begin
               rdata <= {28'h000_0000, config_bits};
            end
            carctc_pkg::ADDR_CHAN_CTRL: begin
               rdata <= {16'h0000, chan_ctrl};
            end
            carctc_pkg::ADDR_MODE: begin
               rdata <= {16'h0000, mode_bits};
            end
            carctc_pkg::ADDR_IRQ_STATUS: begin
               rdata <= {30'h0000_0000, irq_status};
            end
            carctc_pkg::ADDR_IRQ_MASK: begin
               rdata <= {30'h0000_0000, irq_mask};
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   a_count_reconfig: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reconfig |=> count_value == 16'h0000)
      else $error("count not cleared by reconfiguration");
   a_count_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      conv_hit |=> count_value == 16'h0000 && irq_status[0])
      else $error("count did not wrap at limit");
   a_count_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[0] && !reconfig && !conv_hit
      |=> count_value == $past(count_value) + 16'h0001)
      else $error("count did not step by one");
   a_count_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !result.valid && !reconfig |=> $stable(count_value))
      else $error("count moved without a conversion");
   a_count_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[0] |-> !conv_hit)
      else $error("count event while counting disabled");
   a_limit_reset: assert property (@(posedge sys_clk)
      $past(sys_rst) |-> count_limit == 16'h0001 && thr_limit == 8'h01
      && thr_value == 8'h00)
      else $error("reset values wrong");
   a_thr_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[1] && above && thr_value != 8'hff
      |=> thr_value == $past(thr_value) + 8'h01)
      else $error("threshold count did not rise");
   a_thr_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[1] && !above && config_bits[2]
      |=> thr_value == 8'h00)
      else $error("threshold count not cleared");
   a_thr_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      thr_hit |=> irq_status[1] ##0 thr_value == thr_limit)
      else $error("threshold flag not set");
   a_twos_cmp: assert property (@(posedge sys_clk) disable iff (sys_rst)
      config_bits[3] && !result.data[15] && result.data[14:0] < threshold[14:0]
      |-> !above)
      else $error("two's complement compare wrong");

   // register writes land one cycle later
   a_limit_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_COUNT_LIMIT
      |=> count_limit == $past(bus.wdata[15:0])) else $error("limit not written");

   a_thresh_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_THRESHOLD
      |=> threshold == $past(bus.wdata[15:0])) else $error("threshold not written");

   a_tlimit_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_THR_LIMIT
      |=> thr_limit == $past(bus.wdata[7:0])) else $error("tlimit not written");

   a_count_readonly: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_COUNT_VALUE && !result.valid
      |=> $stable(count_value)) else $error("count changed by a write");

   a_count_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[carctc_pkg::CFG_COUNT_EN] && !reconfig
      |=> $stable(count_value)) else $error("count moved while disabled");

   a_wrap_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[carctc_pkg::CFG_COUNT_EN] && !irq_status[0]
      |=> !irq_status[0]) else $error("wrap flag while disabled");

   a_mode_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_MODE
      |=> count_value == 16'h0000) else $error("mode write kept count");

   a_ctrl_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.wr && bus.addr == carctc_pkg::ADDR_CHAN_CTRL
      |=> count_value == 16'h0000) else $error("control write kept count");

   a_wrap_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[0] && !reconfig
      && count_value + 16'h0001 == count_limit
      |=> irq_status[0]) else $error("wrap did not flag");

   a_thr_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[1] && !above && !config_bits[2]
      && thr_value != 8'h00 |=> thr_value == $past(thr_value) - 8'h01)
      else $error("threshold count did not fall");

   a_thr_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[1] && !above && thr_value == 8'h00
      |=> thr_value == 8'h00) else $error("threshold count below zero");

   a_thr_ceiling: assert property (@(posedge sys_clk) disable iff (sys_rst)
      result.valid && config_bits[1] && above && thr_value == 8'hff
      |=> thr_value == 8'hff) else $error("threshold count wrapped");

   a_cmp_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[1] |=> thr_value == 8'h00)
      else $error("threshold count kept while disabled");

   a_thr_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      config_bits[1] && !result.valid |=> $stable(thr_value))
      else $error("threshold count moved without a result");

   a_thr_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[1] && !irq_status[1] |=> !irq_status[1])
      else $error("threshold flag while disabled");

   a_uni_above: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[3] && result.data >= threshold |-> above)
      else $error("unipolar compare missed");

   a_uni_below: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !config_bits[3] && result.data < threshold |-> !above)
      else $error("unipolar compare false hit");

   a_twos_above: assert property (@(posedge sys_clk) disable iff (sys_rst)
      config_bits[3] && !result.data[15]
      && result.data[14:0] >= threshold[14:0] |-> above)
      else $error("two's complement compare missed");

   a_twos_min: assert property (@(posedge sys_clk) disable iff (sys_rst)
      config_bits[3] && result.data == 16'h8000 |-> above)
      else $error("most negative result not above");

   a_irq_raise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_status[0] && irq_mask[0] |-> irq)
      else $error("unmasked wrap without interrupt");

   a_mask_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_mask == 2'h0 |-> !irq)
      else $error("interrupt while fully masked");

   a_status_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      status_clear[0] && !conv_hit |=> !irq_status[0])
      else $error("wrap flag not cleared");

   a_status_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_status[1] && !status_clear[1] |=> irq_status[1])
      else $error("threshold flag lost");

   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !bus.rd |=> rdata == 32'h0000_0000)
      else $error("read data without a read");

   a_limit_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.rd && bus.addr == carctc_pkg::ADDR_COUNT_LIMIT
      |=> rdata == {16'h0000, $past(count_limit)}) else $error("limit read wrong");

   a_tcount_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus.rd && bus.addr == carctc_pkg::ADDR_THR_VALUE
      |=> rdata == {24'h00_0000, $past(thr_value)}) else $error("tcount read wrong");

   c_wrap: cover property (@(posedge sys_clk) disable iff (sys_rst) conv_hit);
   c_thr: cover property (@(posedge sys_clk) disable iff (sys_rst) thr_hit);
   c_irq: cover property (@(posedge sys_clk) disable iff (sys_rst) irq);
   c_reconf: cover property (@(posedge sys_clk) disable iff (sys_rst)
      reconfig && count_value != 16'h0000);
   c_twos_neg: cover property (@(posedge sys_clk) disable iff (sys_rst)
      config_bits[3] && result.valid && result.data[15] && above);
endmodule
`default_nettype wire

// file: verif/test_current_adc_result_counter_threshold.sv
// self-checking bench for the current adc result counter and threshold
`timescale 1ns/1ps
`default_nettype none
module test_current_adc_result_counter_threshold;
   logic sys_clk;
   logic sys_rst;
   carctc_pkg::carctc_bus_t bus;
   logic [31:0] rdata;
   carctc_pkg::carctc_result_t result;
   logic irq;
   logic [15:0] lfsr;
   logic [15:0] d;
   logic [7:0] tc;
   logic ts;
   int n_mismatch;
   int n_tests;
   carctc_top dut_u (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .bus(bus),
      .rdata(rdata),
      .result(result),
      .irq(irq)
   );
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [15:0] step(input logic [15:0] s);
      step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // 17 bits so that the most negative result stays above any threshold
   function automatic logic above(input logic [15:0] x,
                                  input logic [15:0] t, input logic tw);
      logic [16:0] m;
      m = (tw && x[15]) ? 17'h1_0000 - {1'b0, x} : {1'b0, x};
      above = m >= (tw ? {2'b00, t[14:0]} : {1'b0, t});
   endfunction
   task automatic final_report();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] w);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rc(input logic [31:0] a, input logic [31:0] e,
                     input string nm);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   task automatic conv(input logic [15:0] x);
      @(posedge sys_clk);
      result <= '{valid: 1'b1, data: x};
      @(posedge sys_clk);
      result.valid <= 1'b0;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      lfsr = 16'h004e;
      n_mismatch = 0;
      n_tests = 0;
      bus = '0;
      result = '0;
      sys_rst = 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rc(carctc_pkg::ADDR_COUNT_LIMIT, 32'h0000_0001, "limit");
      rc(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0000, "count");
      rc(carctc_pkg::ADDR_THRESHOLD, 32'h0000_0000, "thresh");
      rc(carctc_pkg::ADDR_THR_LIMIT, 32'h0000_0001, "tlimit");
      rc(carctc_pkg::ADDR_THR_VALUE, 32'h0000_0000, "tcount");
      rc(32'hffff_05f0, 32'h0000_0000, "unmapped");
      lfsr = step(lfsr);
      d = 16'h0002 + {14'h0000, lfsr[1:0]};
      wr(carctc_pkg::ADDR_COUNT_LIMIT, {16'hffff, d});
      rc(carctc_pkg::ADDR_COUNT_LIMIT, {16'h0000, d}, "limit");
      wr(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0005);
      wr(carctc_pkg::ADDR_CONFIG, 32'h0000_0001);
      wr(carctc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      repeat (d - 16'h0001) conv(lfsr);
      d = d - 16'h0001;
      rc(carctc_pkg::ADDR_COUNT_VALUE, {16'h0000, d}, "count");
      chk("irq", 32'h0000_0000, {31'h0, irq});
      conv(lfsr);
      rc(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0000, "count");
      rc(carctc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001, "status");
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(carctc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      rc(carctc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, "status");
      chk("irq", 32'h0000_0000, {31'h0, irq});
      conv(lfsr);
      wr(carctc_pkg::ADDR_CHAN_CTRL, 32'h0000_0003);
      rc(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0000, "count");
      conv(lfsr);
      wr(carctc_pkg::ADDR_MODE, 32'h0000_0001);
      rc(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0000, "count");
      wr(carctc_pkg::ADDR_CONFIG, 32'h0000_0000);
      conv(lfsr);
      rc(carctc_pkg::ADDR_COUNT_VALUE, 32'h0000_0000, "count");
      wr(carctc_pkg::ADDR_THR_LIMIT, 32'h0000_0004);
      wr(carctc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
      // modes: bit 0 clear-below, bit 1 two's complement
      for (int m = 0; m < 4; m++) begin
         wr(carctc_pkg::ADDR_CONFIG, 32'h0000_0000);
         conv(16'h0000);
         wr(carctc_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
         tc = 8'h00;
         ts = 1'b0;
         // sign bit set: fails everything unless only 14..0 are used
         wr(carctc_pkg::ADDR_THRESHOLD, m[1] ? 32'h0000_8040 : 32'h0000_0040);
         wr(carctc_pkg::ADDR_CONFIG, {28'h0, m[1], m[0], 2'b10});
         for (int i = 0; i < 24; i++) begin
            lfsr = step(lfsr);
            d = {9'h000, lfsr[6:0]};
            if (m[1] && lfsr[7]) d = -d;
            if (m[1] && i == 5) d = 16'h8000;
            conv(d);
            if (above(d, m[1] ? 16'h8040 : 16'h0040, m[1])) tc = tc + 8'h01;
            else tc = (m[0] || tc == 8'h00) ? 8'h00 : tc - 8'h01;
            ts = ts | (tc == 8'h04);
            rc(carctc_pkg::ADDR_THR_VALUE, {24'h0, tc}, "tcount");
            chk("irq", {31'h0, ts}, {31'h0, irq});
         end
      end
      final_report();
   end
endmodule
`default_nettype wire
